// ### inc/slpd_pkg.sv
package slpd_pkg;
	// ----------------------------------------
	// Register map (word addresses)
	// ----------------------------------------
	localparam logic [15:0] ADDR_LAMP1_CTRL = 16'h404c;
	localparam logic [15:0] ADDR_LAMP2_CTRL = 16'h404d;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int SRC_HI = 15;
	localparam int SRC_LO = 14;
	localparam int PAT_HI = 9;
	localparam int PAT_LO = 8;
	localparam int CNT_HI = 5;
	localparam int CNT_LO = 4;
	localparam int ONT_HI = 3;
	localparam int ONT_LO = 2;
	localparam int RAT_HI = 1;
	localparam int RAT_LO = 0;
	localparam logic [15:0] CTRL_RESET = 16'hc026;
	localparam logic [15:0] CTRL_MASK = 16'hc33f;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_POWER = 2'h1;
	localparam logic [1:0] SRC_MANUAL = 2'h3;
	localparam logic [1:0] PAT_OFF = 2'h0;
	localparam logic [1:0] PAT_CONST = 2'h1;
	localparam logic [1:0] PAT_CONT = 2'h2;
	localparam logic [1:0] PAT_SEQ = 2'h3;
	localparam logic [1:0] ONT_1S = 2'h0;
	localparam logic [1:0] ONT_250MS = 2'h1;
	localparam logic [1:0] RAT_1_1 = 2'h0;
	localparam logic [1:0] RAT_1_3 = 2'h2;
	localparam logic [1:0] RAT_1_7 = 2'h3;
	localparam logic [1:0] CNT_4 = 2'h2;
	// ----------------------------------------
	// Timing: base unit 62.5 ms, given in us
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int UNIT_US = 62500;
	localparam int UNIT_CYCLES = UNIT_US * CLK_MHZ;
	// On time in 62.5 ms units per code: 1 s, 250 ms, 125 ms, 62.5 ms
	localparam logic [4:0] ONT_UNITS_0 = 5'h10;
	localparam logic [4:0] ONT_UNITS_1 = 5'h04;
	localparam logic [4:0] ONT_UNITS_2 = 5'h02;
	localparam logic [4:0] ONT_UNITS_3 = 5'h01;
	// Off multiplier per ratio code: 1, 2, 3, 7
	localparam logic [2:0] RAT_MUL_0 = 3'h1;
	localparam logic [2:0] RAT_MUL_1 = 3'h2;
	localparam logic [2:0] RAT_MUL_2 = 3'h3;
	localparam logic [2:0] RAT_MUL_3 = 3'h7;
	// Pulse count per code: 1, 2, 4, 7
	localparam logic [2:0] CNT_VAL_0 = 3'h1;
	localparam logic [2:0] CNT_VAL_1 = 3'h2;
	localparam logic [2:0] CNT_VAL_2 = 3'h4;
	localparam logic [2:0] CNT_VAL_3 = 3'h7;
	// Pattern request carried to a channel
	typedef struct packed {
		logic enable;
		logic steady;
		logic counted;
		logic [1:0] on_time;
		logic [1:0] ratio;
		logic [1:0] count;
	} slpd_req_t;
	typedef struct packed {
		logic seq_fail;
		logic low_supply;
		logic on_state;
		logic sleep_state;
	} slpd_pwr_t;
endpackage

// ### logic/slpd_pulse.sv
// Pulse train engine for one lamp: on/off timing and optional pulse count
module slpd_pulse #(
	parameter int UNIT_CYC = slpd_pkg::UNIT_CYCLES
) (
	input wire logic sys_clk, // Clock
	input wire logic rst_n, // Async reset
	input wire logic clk_en, // Freeze when low
	input wire logic restart, // Restart the pattern
	input wire slpd_pkg::slpd_req_t req, // Requested pattern
	output logic lamp, // Lamp drive
	output logic done // Counted sequence finished
);
	typedef enum logic [1:0] {slpd_idle, slpd_on, slpd_off, slpd_done} slpd_st_t;
	slpd_st_t st_q;
	logic [31:0] tick_q;
	logic [7:0] unit_q;
	logic [2:0] pulses_q;
	logic tick;
	logic [7:0] on_units;
	logic [7:0] off_units;
	logic [2:0] target;

	// Decode the selected on time, off time and count
	always_comb begin
		case (req.on_time)
			2'h0: on_units = {3'h0, slpd_pkg::ONT_UNITS_0};
			2'h1: on_units = {3'h0, slpd_pkg::ONT_UNITS_1};
			2'h2: on_units = {3'h0, slpd_pkg::ONT_UNITS_2};
			default: on_units = {3'h0, slpd_pkg::ONT_UNITS_3};
		endcase
		case (req.ratio)
			2'h0: off_units = on_units * {5'h0, slpd_pkg::RAT_MUL_0};
			2'h1: off_units = on_units * {5'h0, slpd_pkg::RAT_MUL_1};
			2'h2: off_units = on_units * {5'h0, slpd_pkg::RAT_MUL_2};
			default: off_units = on_units * {5'h0, slpd_pkg::RAT_MUL_3};
		endcase
		case (req.count)
			2'h0: target = slpd_pkg::CNT_VAL_0;
			2'h1: target = slpd_pkg::CNT_VAL_1;
			2'h2: target = slpd_pkg::CNT_VAL_2;
			default: target = slpd_pkg::CNT_VAL_3;
		endcase
	end

	// Slow timebase: one tick every 62.5 ms
	assign tick = (tick_q == 32'(UNIT_CYC - 1));
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 32'h0;
		end else if (clk_en) begin
			if (tick || restart) begin
				tick_q <= 32'h0;
			end else begin
				tick_q <= tick_q + 32'h1;
			end
		end
	end

	// On/off sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= slpd_idle;
			unit_q <= 8'h0;
			pulses_q <= 3'h0;
		end else if (clk_en) begin
			if (restart || !req.enable || req.steady) begin
				st_q <= req.enable && !req.steady ? slpd_on : slpd_idle;
				unit_q <= 8'h0;
				pulses_q <= 3'h0;
			end else begin
				case (st_q)
					slpd_idle: begin
						st_q <= slpd_on;
					end
					slpd_on: begin
						if (tick) begin
							if (unit_q + 8'h1 >= on_units) begin
								unit_q <= 8'h0;
								// Count only in counted mode so a later sequence starts from zero
								pulses_q <= req.counted ? pulses_q + 3'h1 : 3'h0;
								st_q <= slpd_off;
							end else begin
								unit_q <= unit_q + 8'h1;
							end
						end
					end
					slpd_off: begin
						if (tick) begin
							if (unit_q + 8'h1 >= off_units) begin
								unit_q <= 8'h0;
								// Last pulse ends with its off time, then stays dark
								st_q <= (req.counted && pulses_q >= target) ? slpd_done : slpd_on;
							end else begin
								unit_q <= unit_q + 8'h1;
							end
						end
					end
					slpd_done: begin
						// Leave the dark end only on restart, disable or steady request, or if a continuous pattern replaces the sequence
						st_q <= req.counted ? slpd_done : slpd_on;
					end
					default: st_q <= slpd_idle;
				endcase
			end
		end
	end

	// Registered lamp drive
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lamp <= 1'b0;
		end else if (clk_en) begin
			lamp <= req.enable && (req.steady || (st_q == slpd_on && !restart));
		end
	end

	assign done = (st_q == slpd_done);
endmodule

// ### logic/slpd_top.sv
module slpd_top #(
	parameter int UNIT_CYC = slpd_pkg::UNIT_CYCLES // Cycles per 62.5 ms
) (
	input wire logic sys_clk, // Clock 100 MHz
	input wire logic rst_n, // Async reset, active low
	input wire logic clk_en, // Freeze all state when low
	input wire logic [15:0] reg_addr, // Register address
	input wire logic [15:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [15:0] reg_rdata, // Read data, cycle after strobe
	input wire slpd_pkg::slpd_pwr_t pwr, // Power condition indications
	input wire logic prog_done, // Auto-program complete
	input wire logic prog_error, // Auto-program error
	output logic seq_fail_ack, // Four failure pulses emitted
	output logic lamp1, // Lamp channel one
	output logic lamp2 // Lamp channel two
);
	logic [15:0] ctrl_q [2];
	logic [1:0] hit;
	logic restart [2];
	logic [1:0] lamp_raw;
	logic [1:0] seq_done;
	logic force_q [2];
	logic [1:0] prog_in;
	logic [1:0] fail_done;
	logic active;
	slpd_pkg::slpd_req_t req [2];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	assign hit[0] = (reg_addr == slpd_pkg::ADDR_LAMP1_CTRL);
	assign hit[1] = (reg_addr == slpd_pkg::ADDR_LAMP2_CTRL);
	assign prog_in = {prog_error, prog_done};
	assign active = pwr.on_state || pwr.sleep_state;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// Control register per channel, reset values identical
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					ctrl_q[g] <= slpd_pkg::CTRL_RESET;
				end else if (clk_en && reg_wr && hit[g]) begin
					ctrl_q[g] <= reg_wdata & slpd_pkg::CTRL_MASK;
				end
			end

			// A changed source or pattern restarts the channel's pattern
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					restart[g] <= 1'b0;
				end else if (clk_en) begin
					restart[g] <= reg_wr && hit[g] &&
						((reg_wdata[slpd_pkg::SRC_HI:slpd_pkg::SRC_LO] !=
						ctrl_q[g][slpd_pkg::SRC_HI:slpd_pkg::SRC_LO]) ||
						(reg_wdata[slpd_pkg::PAT_HI:slpd_pkg::PAT_LO] !=
						ctrl_q[g][slpd_pkg::PAT_HI:slpd_pkg::PAT_LO]));
				end
			end

			// Auto-program indication latches until device reset
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					force_q[g] <= 1'b0;
				end else if (clk_en && prog_in[g]) begin
					force_q[g] <= 1'b1;
				end
			end

			// Choose the pattern for this channel
			always_comb begin
				logic [1:0] src;
				logic [1:0] pat;
				src = ctrl_q[g][slpd_pkg::SRC_HI:slpd_pkg::SRC_LO];
				pat = ctrl_q[g][slpd_pkg::PAT_HI:slpd_pkg::PAT_LO];
				req[g] = '0;
				if (force_q[g]) begin
					req[g].enable = 1'b1;
					req[g].steady = 1'b1;
				end else if (src == slpd_pkg::SRC_POWER) begin
					// Failure first, then low supply, ON, SLEEP
					if (pwr.seq_fail) begin
						req[g].enable = 1'b1;
						req[g].counted = 1'b1;
						req[g].on_time = slpd_pkg::ONT_1S;
						req[g].ratio = slpd_pkg::RAT_1_1;
						req[g].count = slpd_pkg::CNT_4;
					end else if (pwr.low_supply && active) begin
						req[g].enable = 1'b1;
						req[g].on_time = slpd_pkg::ONT_250MS;
						req[g].ratio = slpd_pkg::RAT_1_3;
					end else if (pwr.on_state) begin
						req[g].enable = 1'b1;
						req[g].steady = 1'b1;
					end else if (pwr.sleep_state) begin
						req[g].enable = 1'b1;
						req[g].on_time = slpd_pkg::ONT_250MS;
						req[g].ratio = slpd_pkg::RAT_1_7;
					end
				end else if (src == slpd_pkg::SRC_MANUAL && active) begin
					// Software drives the lamp directly
					req[g].enable = (pat != slpd_pkg::PAT_OFF);
					req[g].steady = (pat == slpd_pkg::PAT_CONST);
					req[g].counted = (pat == slpd_pkg::PAT_SEQ);
					req[g].on_time = ctrl_q[g][slpd_pkg::ONT_HI:slpd_pkg::ONT_LO];
					req[g].ratio = ctrl_q[g][slpd_pkg::RAT_HI:slpd_pkg::RAT_LO];
					req[g].count = ctrl_q[g][slpd_pkg::CNT_HI:slpd_pkg::CNT_LO];
				end
			end

			slpd_pulse #(
				.UNIT_CYC(UNIT_CYC)
			) u_pulse (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.clk_en(clk_en),
				.restart(restart[g]),
				.req(req[g]),
				.lamp(lamp_raw[g]),
				.done(seq_done[g])
			);

			// Failure sequence finished on a power-status channel
			assign fail_done[g] = seq_done[g] && !force_q[g] && pwr.seq_fail &&
				(ctrl_q[g][slpd_pkg::SRC_HI:slpd_pkg::SRC_LO] == slpd_pkg::SRC_POWER);
		end
	endgenerate

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign lamp1 = lamp_raw[0];
	assign lamp2 = lamp_raw[1];

	// Tells the power sequencer it may now move to OFF
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_fail_ack <= 1'b0;
		end else if (clk_en) begin
			seq_fail_ack <= |fail_done;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0;
		end else if (clk_en) begin
			if (reg_rd && hit[0]) begin
				reg_rdata <= ctrl_q[0];
			end else if (reg_rd && hit[1]) begin
				reg_rdata <= ctrl_q[1];
			end else begin
				reg_rdata <= 16'h0;
			end
		end
	end
endmodule

// ### tb/slpd_checker.sv
module slpd_checker #(
	parameter int UNIT_CYC = 4 // Cycles per time unit
) (
	input wire logic sys_clk, // Clock
	input wire logic rst_n, // Async reset
	input wire logic [15:0] reg_addr, // Address
	input wire logic [15:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [15:0] reg_rdata, // Read data
	input wire slpd_pkg::slpd_pwr_t pwr, // Power state
	input wire logic prog_done, // Program complete
	input wire logic prog_error, // Program error
	input wire logic lamp1, // Lamp one
	input wire logic lamp2 // Lamp two
);
	timeunit 1ns;
	timeprecision 100ps;
	logic done_q, err_q, last_q;
	logic [15:0] sh_q;
	int run_q;
	// --------------------------------
	// Helper state
	// --------------------------------
	// Shadow of lamp one control, so pulse spans are judged only in a known setup
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
			err_q <= 1'b0;
			last_q <= 1'b0;
			run_q <= 0;
			sh_q <= slpd_pkg::CTRL_RESET;
		end else begin
			done_q <= done_q | prog_done;
			err_q <= err_q | prog_error;
			last_q <= lamp1;
			run_q <= (lamp1 != last_q) ? 1 : run_q + 1;
			if (reg_wr && reg_addr == slpd_pkg::ADDR_LAMP1_CTRL) begin
				sh_q <= reg_wdata;
			end
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data not idle");
	rd_unmapped_a: assert property (reg_rd && reg_addr[15:1] != 15'h2026 |=> reg_rdata == 16'h0)
		else $error("unmapped read not zero");
	done_hold_a: assert property ($past(done_q) |-> lamp1)
		else $error("program complete not held");
	err_hold_a: assert property ($past(err_q) |-> lamp2)
		else $error("program error not held");
	src_off_a: assert property (reg_wr && reg_addr == slpd_pkg::ADDR_LAMP1_CTRL
		&& reg_wdata[14] == 1'b0 && !done_q |=> ##1 !lamp1)
		else $error("lamp one lit with source off");
	const_on_a: assert property (reg_wr && reg_addr == slpd_pkg::ADDR_LAMP1_CTRL
		&& reg_wdata[15:8] == 8'hc1 ##2 pwr.on_state |-> lamp1)
		else $error("lamp one not constant");
	pat_off_a: assert property (reg_wr && reg_addr == slpd_pkg::ADDR_LAMP2_CTRL
		&& reg_wdata[15:8] == 8'hc0 && !err_q |=> ##1 !lamp2)
		else $error("lamp two lit with pattern off");
	on_span_a: assert property ($fell(lamp1) && sh_q[15:8] == 8'hc2 && sh_q[3:2] == 2'h3
		&& !done_q |-> run_q == UNIT_CYC)
		else $error("lamp one on span wrong");
endmodule
bind slpd_top slpd_checker #(.UNIT_CYC(UNIT_CYC)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pwr(pwr), .prog_done(prog_done), .prog_error(prog_error),
	.lamp1(lamp1), .lamp2(lamp2));

// ### tb/slpd_lamp_model.sv
module slpd_lamp_model (
	input wire logic sys_clk, // Clock
	input wire logic lamp, // Pin level
	output int pulses, // Flashes seen
	output int on_len, // Last lit span
	output int off_len // Last dark span
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last = 1'b0;
	int run;
	// --------------------------------
	// Lamp observer
	// --------------------------------
	// A lamp only shows what the pin gives; spans are counted in cycles
	always @(posedge sys_clk) begin
		if (lamp !== last) begin
			if (lamp) begin
				pulses <= pulses + 1;
				off_len <= run;
			end else begin
				on_len <= run;
			end
			run <= 1;
		end else begin
			run <= run + 1;
		end
		last <= lamp;
	end
endmodule

// ### tb/slpd_top_bench.sv
module slpd_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int UC = 4;
	localparam int MUL[4] = '{1, 2, 3, 7};
	localparam int CNT[4] = '{1, 2, 4, 7};
	localparam logic [15:0] L1 = slpd_pkg::ADDR_LAMP1_CTRL;
	localparam logic [15:0] L2 = slpd_pkg::ADDR_LAMP2_CTRL;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, prog_done = 1'b0, prog_error = 1'b0;
	logic seq_fail_ack, lamp1, lamp2;
	slpd_pkg::slpd_pwr_t pwr = 4'h0;
	int miscompares = 0;
	int samples_checked = 0;
	int p1, on1, off1, p2, on2, off2;
	// --------------------------------
	// Clock, design and lamps
	// --------------------------------
	always #5 sys_clk = ~sys_clk;
	slpd_top #(.UNIT_CYC(UC)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pwr(pwr), .prog_done(prog_done), .prog_error(prog_error),
		.seq_fail_ack(seq_fail_ack), .lamp1(lamp1), .lamp2(lamp2));
	slpd_lamp_model lamp_a (.sys_clk(sys_clk), .lamp(lamp1), .pulses(p1), .on_len(on1),
		.off_len(off1));
	slpd_lamp_model lamp_b (.sys_clk(sys_clk), .lamp(lamp2), .pulses(p2), .on_len(on2),
		.off_len(off2));
	// --------------------------------
	// Shared tasks
	// --------------------------------
	task chk(string n, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Waits land one step past the edge so registered outputs have settled
	task w(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wr(logic [15:0] a, logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(logic [15:0] a, logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task close_out;
		$display("Compared %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task t_regs;
		rd(L1, slpd_pkg::CTRL_RESET);
		rd(L2, slpd_pkg::CTRL_RESET);
		rd(16'h404e, 16'h0);
		wr(L2, 16'hffff);
		rd(L2, slpd_pkg::CTRL_MASK);
		wr(L2, slpd_pkg::CTRL_RESET);
	endtask
	task t_manual;
		pwr <= 4'h2;
		wr(L1, 16'hc100);
		w(3);
		chk("lamp1", 16'h1, 16'(lamp1));
		wr(L1, 16'h0100);
		w(3);
		chk("lamp1", 16'h0, 16'(lamp1));
		wr(L1, 16'h8100);
		w(3);
		chk("lamp1", 16'h0, 16'(lamp1));
		wr(L1, 16'hc100);
		pwr <= 4'h0;
		w(3);
		chk("lamp1", 16'h0, 16'(lamp1));
		pwr <= 4'h1;
		w(3);
		chk("lamp1", 16'h1, 16'(lamp1));
		pwr <= 4'h2;
		wr(L1, 16'hc000);
	endtask
	task t_pulse;
		for (int r = 0; r < 4; r++) begin
			wr(L1, 16'hc20c | 16'(r));
			w(3 * UC * (1 + MUL[r]) + 5);
			chk("on span", 16'(UC), 16'(on1));
			chk("off span", 16'(UC * MUL[r]), 16'(off1));
		end
		wr(L1, 16'hc208);
		w(60);
		chk("on span", 16'(2 * UC), 16'(on1));
		wr(L1, 16'hc000);
	endtask
	task t_count;
		int p;
		for (int i = 0; i < 4; i++) begin
			wr(L1, 16'hc000);
			p = p1;
			wr(L1, 16'hc30c | 16'(i << 4));
			w(CNT[i] * 2 * UC + 20);
			chk("pulses", 16'(CNT[i]), 16'(p1 - p));
			wr(L1, 16'hc30c | 16'(i << 4));
			w(20);
			chk("pulses", 16'(CNT[i]), 16'(p1 - p));
			chk("lamp1", 16'h0, 16'(lamp1));
		end
	endtask
	task t_power;
		int p;
		wr(L2, 16'h4000);
		pwr <= 4'h1;
		w(300);
		chk("on span", 16'(4 * UC), 16'(on2));
		chk("off span", 16'(28 * UC), 16'(off2));
		pwr <= 4'h3;
		w(3);
		chk("lamp2", 16'h1, 16'(lamp2));
		pwr <= 4'h6;
		w(200);
		chk("on span", 16'(4 * UC), 16'(on2));
		chk("off span", 16'(12 * UC), 16'(off2));
		pwr <= 4'h0;
		w(5);
		chk("ack", 16'h0, 16'(seq_fail_ack));
		p = p2;
		pwr <= 4'he;
		// Four 1 s pulses at 1:1 take 128 units; the margin covers a partial first unit
		w(128 * UC + 20);
		chk("pulses", 16'h4, 16'(p2 - p));
		chk("on span", 16'(16 * UC), 16'(on2));
		chk("off span", 16'(16 * UC), 16'(off2));
		chk("ack", 16'h1, 16'(seq_fail_ack));
		pwr <= 4'h2;
		wr(L2, 16'hc000);
		w(3);
		chk("lamp2", 16'h0, 16'(lamp2));
	endtask
	task t_prog;
		prog_done <= 1'b1;
		w(1);
		prog_done <= 1'b0;
		wr(L1, 16'h0000);
		w(3);
		chk("lamp1", 16'h1, 16'(lamp1));
		prog_error <= 1'b1;
		w(1);
		prog_error <= 1'b0;
		w(20);
		chk("lamp2", 16'h1, 16'(lamp2));
		chk("lamp1", 16'h1, 16'(lamp1));
		rst_n <= 1'b0;
		w(2);
		rst_n <= 1'b1;
		w(3);
		chk("lamps", 16'h0, 16'({lamp1, lamp2}));
	endtask
	// --------------------------------
	// Main sequence and watchdog
	// --------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs;
		t_manual;
		t_pulse;
		t_count;
		t_power;
		t_prog;
		close_out;
	end
	// Whole run needs about 1700 cycles; a hang is cut well past that
	initial begin
		repeat (8000) @(posedge sys_clk);
		miscompares++;
		close_out;
	end
endmodule
